/* design/twm_pkg.sv */
/*
 * twm_pkg: constants, register map and types of the 8-bit timer with
 * waveform mode control.
 * assumes: one clock domain; software reaches the registers over a plain
 * address/strobe port with read data one cycle after the read strobe.
 */
package twm_pkg;

   // register offsets
   localparam logic [7:0] TWM_OFF_CTRL_B = 8'h18;
   localparam logic [7:0] TWM_OFF_CTRL_A = 8'h19;
   localparam logic [7:0] TWM_OFF_COUNT = 8'h1a;
   localparam logic [7:0] TWM_OFF_CMP_A = 8'h1b;
   localparam logic [7:0] TWM_OFF_CMP_B = 8'h1c;
   localparam logic [7:0] TWM_OFF_STATUS = 8'h1d;
   localparam logic [7:0] TWM_OFF_CLEAR = 8'h1e;
   localparam logic [7:0] TWM_OFF_ENABLE = 8'h1f;

   // control register a fields
   localparam int TWM_CA_COM_A_HI = 7;
   localparam int TWM_CA_COM_A_LO = 6;
   localparam int TWM_CA_COM_B_HI = 5;
   localparam int TWM_CA_COM_B_LO = 4;
   localparam int TWM_CA_SEL_HI = 1;
   localparam int TWM_CA_SEL_LO = 0;

   // control register b fields
   localparam int TWM_CB_FORCE_A = 7;
   localparam int TWM_CB_FORCE_B = 6;
   localparam int TWM_CB_BIT2 = 3;
   localparam int TWM_CB_CS_HI = 2;
   localparam int TWM_CB_CS_LO = 0;

   // status, clear and enable layout
   localparam int TWM_ST_OVF = 0;
   localparam int TWM_ST_MATCH_A = 1;
   localparam int TWM_ST_MATCH_B = 2;
   localparam int TWM_ST_W = 3;

   // reset values and count limits
   localparam logic [7:0] TWM_CTRL_RESET = 8'h00;
   localparam logic [7:0] TWM_MAX = 8'hff;
   localparam logic [7:0] TWM_BOTTOM = 8'h00;

   // waveform mode codes
   localparam logic [2:0] TWM_MODE_NORMAL = 3'h0;
   localparam logic [2:0] TWM_MODE_PHASE_FF = 3'h1;
   localparam logic [2:0] TWM_MODE_CTC = 3'h2;
   localparam logic [2:0] TWM_MODE_FAST_FF = 3'h3;
   localparam logic [2:0] TWM_MODE_PHASE_A = 3'h5;
   localparam logic [2:0] TWM_MODE_FAST_A = 3'h7;

   // clock select codes
   localparam logic [2:0] TWM_CS_STOP = 3'h0;
   localparam logic [2:0] TWM_CS_DIV1 = 3'h1;
   localparam logic [2:0] TWM_CS_DIV8 = 3'h2;
   localparam logic [2:0] TWM_CS_DIV64 = 3'h3;
   localparam logic [2:0] TWM_CS_DIV256 = 3'h4;
   localparam logic [2:0] TWM_CS_DIV1024 = 3'h5;
   localparam logic [2:0] TWM_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] TWM_CS_EXT_RISE = 3'h7;

   // prescaler width and tap masks
   localparam int TWM_PRE_W = 10;
   localparam logic [9:0] TWM_PRE_MASK8 = 10'h007;
   localparam logic [9:0] TWM_PRE_MASK64 = 10'h03f;
   localparam logic [9:0] TWM_PRE_MASK256 = 10'h0ff;
   localparam logic [9:0] TWM_PRE_MASK1024 = 10'h3ff;

   // output mode codes
   localparam logic [1:0] TWM_COM_OFF = 2'h0;
   localparam logic [1:0] TWM_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TWM_COM_CLEAR = 2'h2;
   localparam logic [1:0] TWM_COM_SET = 2'h3;

   typedef enum logic [1:0] {CLS_NORMAL, CLS_CTC, CLS_FAST, CLS_PHASE} twm_class_type;
   typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} twm_act_type;

   typedef struct packed {
      logic [1:0] com_a;
      logic [1:0] com_b;
      logic [1:0] sel;
      logic bit2;
      logic [2:0] cs;
      logic [7:0] cnt;
      logic down;
      logic [7:0] cmp_a_buf;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b_buf;
      logic [7:0] cmp_b;
      logic block;
      logic [TWM_PRE_W-1:0] pre;
      logic ext_prev;
      logic [TWM_ST_W-1:0] status;
      logic [TWM_ST_W-1:0] enable;
      logic irq;
      logic wave_a;
      logic wave_b;
      logic en_a;
      logic en_b;
      logic oe_a;
      logic oe_b;
      logic [7:0] rdata;
   } twm_state_type;

endpackage

/* design/twm_timer.sv */
/*
 * twm_timer: 8-bit timer/counter with mode selection, compare buffering,
 * overflow and match flags, and two waveform output channels.
 * assumes: all inputs synchronous to REF_CLK; pin direction bits come from
 * the port logic; the port logic muxes WAVE_x onto the pin while WAVE_x_EN.
 */
`timescale 1ns/1ps

//Behaviour
//[RQ1] nonzero output mode takes pin; driver needs direction
//[RQ2] non-PWM channel A: off, toggle, clear, set
//[RQ3] fast PWM A: clear/set match, opposite at bottom
//[RQ4] PWM A code 01 toggles only with bit2
//[RQ5] fast PWM compare equal top: act at bottom
//[RQ6] phase PWM A: up-match and down-match opposite
//[RQ7] phase PWM compare equal top: act at top
//[RQ8] non-PWM channel B: off, toggle, clear, set
//[RQ9] fast PWM B: 01 reserved, 10/11 as A
//[RQ10] phase PWM B: 01 reserved, 10/11 as A
//[RQ11] three mode bits pick counting and top
//[RQ12] compare update immediate, at top, at bottom
//[RQ13] overflow flag point depends on mode
//[RQ14] counter advances only on tick enable
//[RQ15] compare A top clears counter; flags on match
//[RQ16] reserved control bits read zero
//[RQ17] clock select: stop, divided, external edges
//[RQ18] force strobe acts immediately, reads zero
//[RQ19] reset leaves everything zero and stopped
module twm_timer
   import twm_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic EXT_T,
   input wire logic DIR_A,
   input wire logic DIR_B,
   output logic WAVE_A,
   output logic WAVE_A_EN,
   output logic WAVE_A_OE,
   output logic WAVE_B,
   output logic WAVE_B_EN,
   output logic WAVE_B_OE,
   output logic IRQ
);

   twm_state_type st;
   twm_state_type next_st;
   twm_class_type cls;
   logic [7:0] top;
   logic tick;
   logic turn;
   logic match_a;
   logic match_b;
   logic force_a;
   logic force_b;
   logic ovf_evt;
   logic immediate;
   logic take_a;
   logic [TWM_ST_W-1:0] set_bits;
   logic [TWM_ST_W-1:0] clr_bits;
   twm_act_type act_a;
   twm_act_type act_b;

   // mode code to counting class
   function automatic twm_class_type mode_class(input logic [2:0] mode);
      case (mode)
         TWM_MODE_PHASE_FF, TWM_MODE_PHASE_A: mode_class = CLS_PHASE; // RQ11
         TWM_MODE_CTC: mode_class = CLS_CTC;
         TWM_MODE_FAST_FF, TWM_MODE_FAST_A: mode_class = CLS_FAST;
         default: mode_class = CLS_NORMAL;
      endcase
   endfunction

   // timer tick from clock select
   function automatic logic pre_tick(input logic [2:0] cs, input logic [TWM_PRE_W-1:0] pre,
                                     input logic prev, input logic now);
      case (cs)
         TWM_CS_DIV1: pre_tick = 1'b1; // RQ17
         TWM_CS_DIV8: pre_tick = (pre & TWM_PRE_MASK8) == TWM_PRE_MASK8;
         TWM_CS_DIV64: pre_tick = (pre & TWM_PRE_MASK64) == TWM_PRE_MASK64;
         TWM_CS_DIV256: pre_tick = (pre & TWM_PRE_MASK256) == TWM_PRE_MASK256;
         TWM_CS_DIV1024: pre_tick = (pre & TWM_PRE_MASK1024) == TWM_PRE_MASK1024;
         TWM_CS_EXT_FALL: pre_tick = prev && !now;
         TWM_CS_EXT_RISE: pre_tick = !prev && now;
         default: pre_tick = 1'b0;
      endcase
   endfunction

   // output action of one channel
   function automatic twm_act_type chan_act(input twm_class_type c, input logic [1:0] com,
                                            input logic tog_ok, input logic match, input logic up,
                                            input logic turn_evt, input logic at_top);
      chan_act = ACT_NONE;
      case (c)
         CLS_NORMAL, CLS_CTC: begin
            if (match) begin
               case (com)
                  TWM_COM_TOGGLE: chan_act = ACT_TOGGLE; // RQ2 RQ8
                  TWM_COM_CLEAR: chan_act = ACT_CLEAR;
                  TWM_COM_SET: chan_act = ACT_SET;
                  default: chan_act = ACT_NONE;
               endcase
            end
         end
         CLS_FAST: begin
            if (com == TWM_COM_TOGGLE) begin
               if (tog_ok && match) begin
                  chan_act = ACT_TOGGLE; // RQ4
               end
            end else if (com[1]) begin
               if (turn_evt) begin
                  chan_act = (com == TWM_COM_CLEAR) ? ACT_SET : ACT_CLEAR; // RQ3 RQ9 RQ5
               end else if (match && !at_top) begin
                  chan_act = (com == TWM_COM_CLEAR) ? ACT_CLEAR : ACT_SET; // RQ3 RQ9
               end
            end
         end
         CLS_PHASE: begin
            if (com == TWM_COM_TOGGLE) begin
               if (tog_ok && match) begin
                  chan_act = ACT_TOGGLE; // RQ4
               end
            end else if (com[1]) begin
               if (at_top) begin
                  if (turn_evt) begin
                     chan_act = (com == TWM_COM_CLEAR) ? ACT_CLEAR : ACT_SET; // RQ7
                  end
               end else if (match) begin
                  if (up == (com == TWM_COM_CLEAR)) begin
                     chan_act = ACT_CLEAR; // RQ6 RQ10
                  end else begin
                     chan_act = ACT_SET;
                  end
               end
            end
         end
         default: chan_act = ACT_NONE;
      endcase
   endfunction

   function automatic logic wave_apply(input logic cur, input twm_act_type a);
      case (a)
         ACT_TOGGLE: wave_apply = !cur;
         ACT_CLEAR: wave_apply = 1'b0;
         ACT_SET: wave_apply = 1'b1;
         default: wave_apply = cur;
      endcase
   endfunction

   always_comb begin
      next_st = st;
      cls = mode_class({st.bit2, st.sel}); // RQ11
      top = (st.bit2 || ({st.bit2, st.sel} == TWM_MODE_CTC)) ? st.cmp_a : TWM_MAX; // RQ11
      immediate = (cls == CLS_NORMAL) || (cls == CLS_CTC);
      tick = pre_tick(st.cs, st.pre, st.ext_prev, EXT_T); // RQ17
      turn = tick && (st.cnt == top) && !st.down;
      match_a = tick && !st.block && (st.cnt == st.cmp_a); // RQ14
      match_b = tick && !st.block && (st.cnt == st.cmp_b);
      force_a = WR && (ADDR == TWM_OFF_CTRL_B) && WDATA[TWM_CB_FORCE_A] && immediate; // RQ18
      force_b = WR && (ADDR == TWM_OFF_CTRL_B) && WDATA[TWM_CB_FORCE_B] && immediate; // RQ18
      next_st.pre = st.pre + 10'h001;
      next_st.ext_prev = EXT_T;

      // counting
      if (tick) begin
         next_st.block = 1'b0;
         case (cls)
            CLS_CTC, CLS_FAST: begin
               next_st.cnt = (st.cnt == top) ? TWM_BOTTOM : st.cnt + 8'h01; // RQ15
               next_st.down = 1'b0;
            end
            CLS_PHASE: begin
               if (!st.down) begin
                  if (st.cnt == top) begin
                     next_st.down = 1'b1;
                     next_st.cnt = (st.cnt == TWM_BOTTOM) ? st.cnt : st.cnt - 8'h01;
                  end else begin
                     next_st.cnt = st.cnt + 8'h01;
                  end
               end else if (st.cnt == TWM_BOTTOM) begin
                  next_st.down = 1'b0;
                  next_st.cnt = st.cnt + 8'h01;
               end else begin
                  next_st.cnt = st.cnt - 8'h01;
               end
            end
            default: begin
               next_st.cnt = st.cnt + 8'h01; // RQ14
               next_st.down = 1'b0;
            end
         endcase
      end

      // overflow point per mode
      case (cls)
         CLS_PHASE: ovf_evt = tick && st.down && (st.cnt == TWM_BOTTOM); // RQ13
         CLS_FAST: ovf_evt = tick && (st.cnt == (st.bit2 ? top : TWM_MAX)); // RQ13
         default: ovf_evt = tick && (st.cnt == TWM_MAX); // RQ13
      endcase

      // compare buffer transfer
      if (immediate || turn) begin
         next_st.cmp_a = st.cmp_a_buf; // RQ12
         next_st.cmp_b = st.cmp_b_buf;
      end

      // waveform channels
      act_a = chan_act(cls, st.com_a, st.bit2, match_a || force_a, !st.down, turn, st.cmp_a == top);
      act_b = chan_act(cls, st.com_b, 1'b0, match_b || force_b, !st.down, turn, st.cmp_b == top);
      next_st.wave_a = wave_apply(st.wave_a, act_a);
      next_st.wave_b = wave_apply(st.wave_b, act_b);
      // pwm code 01 without bit2 leaves pin a to the port; channel b still takes its pin
      take_a = (|st.com_a) && (immediate || st.bit2 || (st.com_a != TWM_COM_TOGGLE)); // RQ4
      next_st.en_a = take_a; // RQ1
      next_st.en_b = |st.com_b; // RQ1
      next_st.oe_a = take_a && DIR_A; // RQ1
      next_st.oe_b = (|st.com_b) && DIR_B; // RQ1

      // register writes
      clr_bits = '0;
      if (WR) begin
         case (ADDR)
            TWM_OFF_CTRL_A: begin
               next_st.com_a = WDATA[TWM_CA_COM_A_HI:TWM_CA_COM_A_LO];
               next_st.com_b = WDATA[TWM_CA_COM_B_HI:TWM_CA_COM_B_LO];
               next_st.sel = WDATA[TWM_CA_SEL_HI:TWM_CA_SEL_LO];
            end
            TWM_OFF_CTRL_B: begin
               next_st.bit2 = WDATA[TWM_CB_BIT2];
               next_st.cs = WDATA[TWM_CB_CS_HI:TWM_CB_CS_LO];
            end
            TWM_OFF_COUNT: begin
               next_st.cnt = WDATA;
               next_st.block = 1'b1;
            end
            TWM_OFF_CMP_A: begin
               next_st.cmp_a_buf = WDATA;
               if (immediate) begin
                  next_st.cmp_a = WDATA; // RQ12
               end
            end
            TWM_OFF_CMP_B: begin
               next_st.cmp_b_buf = WDATA;
               if (immediate) begin
                  next_st.cmp_b = WDATA; // RQ12
               end
            end
            TWM_OFF_CLEAR: clr_bits = WDATA[TWM_ST_W-1:0];
            TWM_OFF_ENABLE: next_st.enable = WDATA[TWM_ST_W-1:0];
            default: next_st.enable = st.enable;
         endcase
      end

      // sticky flags, set wins over clear
      set_bits = '0;
      set_bits[TWM_ST_OVF] = ovf_evt; // RQ13
      set_bits[TWM_ST_MATCH_A] = match_a; // RQ15
      set_bits[TWM_ST_MATCH_B] = match_b; // RQ15
      next_st.status = (st.status & ~clr_bits) | set_bits;
      next_st.irq = |(next_st.status & next_st.enable);

      // read data, one cycle after the strobe
      next_st.rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            TWM_OFF_CTRL_A: next_st.rdata = {st.com_a, st.com_b, 2'b00, st.sel}; // RQ16
            TWM_OFF_CTRL_B: next_st.rdata = {2'b00, 2'b00, st.bit2, st.cs}; // RQ16 RQ18
            TWM_OFF_COUNT: next_st.rdata = st.cnt;
            TWM_OFF_CMP_A: next_st.rdata = st.cmp_a_buf;
            TWM_OFF_CMP_B: next_st.rdata = st.cmp_b_buf;
            TWM_OFF_STATUS: next_st.rdata = {5'h00, st.status};
            TWM_OFF_ENABLE: next_st.rdata = {5'h00, st.enable};
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st <= '0; // RQ19
      end else begin
         st <= next_st;
      end
   end

   assign RDATA = st.rdata;
   assign WAVE_A = st.wave_a;
   assign WAVE_A_EN = st.en_a;
   assign WAVE_A_OE = st.oe_a;
   assign WAVE_B = st.wave_b;
   assign WAVE_B_EN = st.en_b;
   assign WAVE_B_OE = st.oe_b;
   assign IRQ = st.irq;

   // checks
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);

   sequence s_read_a;
      RD && (ADDR == TWM_OFF_CTRL_A);
   endsequence

   sequence s_read_b;
      RD && (ADDR == TWM_OFF_CTRL_B);
   endsequence

   sequence s_ctc_wrap;
      (cls == CLS_CTC) && tick && !st.block && (st.cnt == st.cmp_a) && !(WR && ADDR == TWM_OFF_COUNT);
   endsequence

   sequence s_pwm_code01_a;
      ((cls == CLS_FAST) || (cls == CLS_PHASE)) && (st.com_a == TWM_COM_TOGGLE) && !st.bit2;
   endsequence

   sequence s_fast_bottom_a;
      (cls == CLS_FAST) && turn && (st.com_a == TWM_COM_CLEAR) && !force_a;
   endsequence

   AST_RESERVED_ZERO: assert property (s_read_a |=> RDATA[3:2] == 2'b00) // RQ16
      else $error("reserved control a bits read nonzero");

   AST_FORCE_READS_ZERO: assert property (s_read_b |=> RDATA[7:4] == 4'h0) // RQ18
      else $error("force or reserved bits read nonzero");

   AST_DRIVER_NEEDS_DIR: assert property (##1 WAVE_A_OE == $past(DIR_A && (st.com_a != TWM_COM_OFF)
      && !(((cls == CLS_FAST) || (cls == CLS_PHASE)) && !st.bit2 && (st.com_a == TWM_COM_TOGGLE)))) // RQ1
      else $error("channel a driver enable wrong");

   AST_PWM_CODE01_FREE: assert property (s_pwm_code01_a |=> !WAVE_A_EN) // RQ4
      else $error("channel a taken by pwm code 01 without bit2");

   AST_FORCE_NO_FLAG: assert property (force_a && !match_a && !st.status[TWM_ST_MATCH_A]
                                       |=> !st.status[TWM_ST_MATCH_A]) // RQ18
      else $error("force strobe set the match flag");

   AST_PHASE_TOP_B: assert property ((cls == CLS_PHASE) && turn && (st.com_b == TWM_COM_CLEAR)
                                     && (st.cmp_b == top) |=> !WAVE_B) // RQ7
      else $error("channel b not cleared at top");

   AST_STOPPED: assert property ((st.cs == TWM_CS_STOP) && !(WR && ADDR == TWM_OFF_COUNT)
                                 |=> $stable(st.cnt)) // RQ17
      else $error("counter moved while stopped");

   AST_DIV8: assert property ((st.cs == TWM_CS_DIV8) && tick |-> st.pre[2:0] == 3'h7) // RQ17
      else $error("divide by eight tick misplaced");

   AST_HOLD_NO_TICK: assert property (!tick && !(WR && ADDR == TWM_OFF_COUNT) |=> $stable(st.cnt)) // RQ14
      else $error("counter moved without tick");

   AST_CTC_CLEAR: assert property (s_ctc_wrap |=> st.cnt == TWM_BOTTOM && st.status[TWM_ST_MATCH_A]) // RQ15
      else $error("match in clear mode did not clear counter and flag");

   AST_NONPWM_SET: assert property ((cls == CLS_NORMAL) && (st.com_a == TWM_COM_SET) && match_a |=> WAVE_A) // RQ2
      else $error("channel a not set on match");

   AST_FAST_BOTTOM: assert property (s_fast_bottom_a |=> WAVE_A) // RQ3
      else $error("fast mode did not set channel a at bottom");

   AST_OVF_NORMAL: assert property ((cls == CLS_NORMAL) && tick && (st.cnt == TWM_MAX)
                                    |=> st.status[TWM_ST_OVF] && (IRQ || !st.enable[TWM_ST_OVF])) // RQ13
      else $error("overflow flag not set at max");

   AST_PHASE_LOAD: assert property ((cls == CLS_PHASE) && turn && !(WR && ADDR == TWM_OFF_CMP_A)
                                    |=> st.cmp_a == $past(st.cmp_a_buf)) // RQ12
      else $error("compare a not loaded at top");

endmodule // twm_timer

/* testbench/twm_pin_model.sv */
/*
 * twm_pin_model: port pin beside one wave output, plus the external count source.
 * assumes: wave and output enable come straight from the timer; port_level is the port's own value.
 */
`timescale 1ns/1ps
module twm_pin_model (
   input wire logic clk,
   input wire logic wave,
   input wire logic oe,
   input wire logic port_level,
   input wire logic ext_run,
   output logic pin,
   output logic ext_t
);
   logic [1:0] div;
   // driver only while the timer owns the pin
   assign pin = oe ? wave : port_level;
   initial begin
      div = 2'h0;
      ext_t = 1'b0;
   end
   // one rising and one falling edge every 8 clocks
   always_ff @(posedge clk) begin
      div <= div + 2'h1;
      if (ext_run && div == 2'h3) begin
         ext_t <= ~ext_t;
      end
   end
endmodule // twm_pin_model

/* testbench/twm_timer_tb.sv */
/*
 * twm_timer_tb: self-checking bench for the timer with waveform modes.
 * assumes: twm_pkg and twm_timer compiled first; pin models on both outputs.
 */
`timescale 1ns/1ps
module twm_timer_tb;
   import twm_pkg::*;
   logic REF_CLK, SYS_RST, WR, RD, EXT_T, DIR_A, DIR_B, ext_run, w;
   logic WAVE_A, WAVE_A_EN, WAVE_A_OE, WAVE_B, WAVE_B_EN, WAVE_B_OE, IRQ, pin_a, pin_b;
   logic [7:0] ADDR, WDATA, RDATA, d, m;
   logic [15:0] len;
   int failures, checks_done, seed;
   int divs [8] = '{0, 1, 8, 64, 256, 1024, 8, 8};
   logic [7:0] mode_flags [8] = '{8'h07, 8'h06, 8'h02, 8'h07, 8'h07, 8'h03, 8'h07, 8'h03};

   twm_timer uut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .EXT_T(EXT_T), .DIR_A(DIR_A), .DIR_B(DIR_B), .WAVE_A(WAVE_A), .WAVE_A_EN(WAVE_A_EN),
      .WAVE_A_OE(WAVE_A_OE), .WAVE_B(WAVE_B), .WAVE_B_EN(WAVE_B_EN), .WAVE_B_OE(WAVE_B_OE), .IRQ(IRQ));
   twm_pin_model pa (.clk(REF_CLK), .wave(WAVE_A), .oe(WAVE_A_OE), .port_level(1'b0), .ext_run(ext_run),
      .pin(pin_a), .ext_t(EXT_T));
   twm_pin_model pb (.clk(REF_CLK), .wave(WAVE_B), .oe(WAVE_B_OE), .port_level(1'b0), .ext_run(1'b0),
      .pin(pin_b), .ext_t());

   initial begin
      REF_CLK = 1'b0;
      forever #12.5 REF_CLK = ~REF_CLK;
   end

   task automatic final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick;
      @(posedge REF_CLK);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge REF_CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge REF_CLK);
      WR <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge REF_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge REF_CLK);
      RD <= 1'b0;
      #1;
      v = RDATA;
   endtask

   function automatic logic wv(input logic ch);
      return ch ? WAVE_B : WAVE_A;
   endfunction

   // expected run length of a wave level
   function automatic logic [15:0] exp_len(input logic [2:0] mode, input logic [7:0] c, input int div);
      if (mode == TWM_MODE_PHASE_FF || mode == TWM_MODE_PHASE_A) begin
         return 16'(2 * c);
      end
      return 16'(div * (c + 1));
   endfunction

   // stop, load compares in immediate mode, then start the wanted mode
   task automatic cfg(input logic [2:0] mode, input logic [3:0] com, input logic [2:0] cs,
      input logic [7:0] ca, input logic [7:0] cb);
      wr(TWM_OFF_CTRL_B, 8'h00);
      wr(TWM_OFF_CTRL_A, 8'h00);
      wr(TWM_OFF_CMP_A, ca);
      wr(TWM_OFF_CMP_B, cb);
      wr(TWM_OFF_COUNT, 8'h00);
      wr(TWM_OFF_CLEAR, 8'h07);
      wr(TWM_OFF_CTRL_A, {com, 2'h0, mode[1:0]});
      wr(TWM_OFF_CTRL_B, {4'h0, mode[2], cs});
   endtask

   // length of the next full run of lvl
   task automatic check_run(input string what, input logic ch, input logic lvl, input logic [15:0] exp);
      int g;
      g = 0;
      len = 16'h0;
      while (wv(ch) === lvl && g < 20000) begin
         tick;
         g++;
      end
      while (wv(ch) !== lvl && g < 20000) begin
         tick;
         g++;
      end
      while (wv(ch) === lvl && g < 20000) begin
         tick;
         g++;
         len++;
      end
      if (g >= 20000) begin
         failures++;
         final_report;
      end
      chk(what, len, exp);
   endtask

   task automatic hold(input string what, input logic ch, input logic lvl, input int n);
      logic [15:0] bad;
      bad = 16'h0;
      repeat (n) begin
         tick;
         if (wv(ch) !== lvl) begin
            bad++;
         end
      end
      chk(what, bad, 16'h0);
   endtask

   initial begin
      seed = 37569;
      failures = 0;
      checks_done = 0;
      ADDR = 8'h00;
      WDATA = 8'h00;
      WR = 1'b0;
      RD = 1'b0;
      DIR_A = 1'b1;
      DIR_B = 1'b1;
      ext_run = 1'b0;
      SYS_RST = 1'b1;
      repeat (3) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      tick;
      chk("en_a", {11'h0, WAVE_A_EN, WAVE_B_EN, WAVE_A_OE, WAVE_B_OE, IRQ}, 16'h0);
      rd(TWM_OFF_CTRL_A, d);
      chk("ctrl_a", 16'(d), 16'h0);
      wr(TWM_OFF_CTRL_A, 8'h0c);
      rd(TWM_OFF_CTRL_A, d);
      chk("ctrl_a spare", 16'(d), 16'h0);
      wr(TWM_OFF_CTRL_B, 8'h30);
      rd(TWM_OFF_CTRL_B, d);
      chk("ctrl_b spare", 16'(d), 16'h0);
      rd(8'h00, d);
      chk("unmapped", 16'(d), 16'h0);
      // force strobes with every nonzero output code
      for (int ch = 0; ch < 2; ch++) begin
         w = 1'b0;
         for (int c = 1; c < 4; c++) begin
            wr(TWM_OFF_CTRL_A, ch ? 8'(c << 4) : 8'(c << 6));
            wr(TWM_OFF_CTRL_B, ch ? 8'h40 : 8'h80);
            w = (c == 1) ? ~w : c[0];
            tick;
            tick;
            chk("forced wave", 16'(wv(ch[0])), 16'(w));
         end
      end
      chk("en pair", {14'h0, WAVE_A_EN, WAVE_B_EN}, 16'h1);
      chk("pin driven", 16'(pin_b), 16'h1);
      @(posedge REF_CLK);
      DIR_B <= 1'b0;
      tick;
      tick;
      chk("pin released", 16'(pin_b), 16'h0);
      rd(TWM_OFF_CTRL_B, d);
      chk("force reads", 16'(d), 16'h0);
      rd(TWM_OFF_STATUS, d);
      chk("force flags", 16'(d), 16'h0);
      m = 8'h10 + 8'($random(seed) & 32'h3f);
      for (int md = 0; md < 8; md++) begin
         cfg(3'(md), 4'hf, TWM_CS_DIV1, m, m + 8'h08);
         repeat (300) tick;
         wr(TWM_OFF_CTRL_B, 8'h00);
         rd(TWM_OFF_STATUS, d);
         chk("mode flags", 16'(d), 16'(mode_flags[md]));
      end
      wr(TWM_OFF_ENABLE, 8'h04);
      tick;
      chk("irq masked", 16'(IRQ), 16'h0);
      wr(TWM_OFF_ENABLE, 8'h02);
      tick;
      chk("irq", 16'(IRQ), 16'h1);
      wr(TWM_OFF_CLEAR, 8'h02);
      tick;
      chk("irq cleared", 16'(IRQ), 16'h0);
      rd(TWM_OFF_STATUS, d);
      chk("flags left", 16'(d), 16'h01);
      for (int cs = 1; cs < 8; cs++) begin
         ext_run = (cs > 5);
         cfg(TWM_MODE_CTC, 4'h4, 3'(cs), 8'h02, 8'h00);
         check_run("ctc half", 1'b0, 1'b1, exp_len(TWM_MODE_CTC, 8'h02, divs[cs]));
      end
      cfg(TWM_MODE_CTC, 4'h4, TWM_CS_STOP, 8'h02, 8'h00);
      hold("stopped", 1'b0, WAVE_A, 100);
      cfg(TWM_MODE_FAST_FF, 4'ha, TWM_CS_DIV1, m, m + 8'h08);
      check_run("fast a high", 1'b0, 1'b1, exp_len(TWM_MODE_FAST_FF, m, 1));
      check_run("fast b high", 1'b1, 1'b1, exp_len(TWM_MODE_FAST_FF, m + 8'h08, 1));
      cfg(TWM_MODE_FAST_FF, 4'hf, TWM_CS_DIV1, m, m + 8'h08);
      check_run("fast a low", 1'b0, 1'b0, exp_len(TWM_MODE_FAST_FF, m, 1));
      check_run("fast b low", 1'b1, 1'b0, exp_len(TWM_MODE_FAST_FF, m + 8'h08, 1));
      cfg(TWM_MODE_FAST_FF, 4'h5, TWM_CS_DIV1, m, m + 8'h08);
      hold("fast a off", 1'b0, WAVE_A, 600);
      hold("fast b spare", 1'b1, WAVE_B, 600);
      chk("a released", {13'h0, WAVE_A_EN, WAVE_A_OE, pin_a}, 16'h0);
      cfg(TWM_MODE_FAST_A, 4'h6, TWM_CS_DIV1, m, m);
      check_run("fast toggle", 1'b0, 1'b1, exp_len(TWM_MODE_FAST_A, m, 1));
      chk("a driven", {14'h0, WAVE_A_EN, WAVE_A_OE}, 16'h3);
      hold("fast b at top", 1'b1, 1'b1, 200);
      cfg(TWM_MODE_PHASE_FF, 4'hb, TWM_CS_DIV1, m, m + 8'h08);
      check_run("phase a high", 1'b0, 1'b1, exp_len(TWM_MODE_PHASE_FF, m, 1));
      check_run("phase b low", 1'b1, 1'b0, exp_len(TWM_MODE_PHASE_FF, m + 8'h08, 1));
      cfg(TWM_MODE_PHASE_A, 4'ha, TWM_CS_DIV1, m, m);
      repeat (200) tick;
      hold("phase b at top", 1'b1, 1'b0, 200);
      final_report;
   end
endmodule // twm_timer_tb
